// ---- ctm_pkg.sv ----
// Summary of operation
// - With clear_on_match_enable set, counter returns to zero the cycle after compare A match.
// - With pwm_a_enable set, PWM uses compare A; counter clears after compare C match.
// - Outside PWM, action field on match: 00 off, 01 toggle, 10 low, 11 high.
// - Clock select: 0 stops, 1-4 fast clock /1../8, 5-15 system clock /1../1024.
// - Writing force_compare_a applies the output action as a match would, no flag.
// - force_compare_a reads zero and is ignored while PWM is enabled.
// - prescaler_reset_strobe resets both prescalers, not the counter; reads zero.
// - Software counter write takes effect one clock cycle later.
// - Compare A matches only when counting onto its value, never on a write.
// - Compare A flag sets after a one-cycle synchronisation delay after the match.
// - Compare C matches only on counting; with clear_on_match it clears the counter.
// - Compare A interrupt requested only when enable, global bit and flag all set.
// - Overflow interrupt requested only when enable, global bit and flag all set.
// - Compare A flag clears on vector execution, or a cycle after writing one.
// - Overflow flag sets on overflow; clears on vector or a cycle after writing one.
// - Bits 7 and 0 of the mask and flag registers always read zero.
// - Overflow on wrap 0xff to zero; in PWM also on compare C clear.
// - PWM action 10 low on match, high at count one; 11 the reverse; else off.
// - PWM compare A writes go to a holding register, loaded at compare C match.
package ctm_pkg;

  localparam logic [7:0] CTM_OFS_GEN_CTRL  = 8'h2c;
  localparam logic [7:0] CTM_OFS_CTRL      = 8'h30;
  localparam logic [7:0] CTM_OFS_FLAGS     = 8'h38;
  localparam logic [7:0] CTM_OFS_COUNT     = 8'h40;
  localparam logic [7:0] CTM_OFS_CMP_A     = 8'h44;
  localparam logic [7:0] CTM_OFS_CMP_C     = 8'h48;
  localparam logic [7:0] CTM_OFS_MASK      = 8'h4c;

  localparam int CTM_BIT_FORCE_A  = 2;
  localparam int CTM_BIT_PSC_RST  = 1;
  localparam int CTM_BIT_FLAG_A   = 6;
  localparam int CTM_BIT_FLAG_OVF = 2;

  localparam logic [7:0] CTM_RST_CTRL  = 8'h00;
  localparam logic [7:0] CTM_RST_MASK  = 8'h00;
  localparam logic [7:0] CTM_RST_CMP_A = 8'h00;
  localparam logic [7:0] CTM_RST_CMP_C = 8'hff;
  localparam logic [7:0] CTM_CNT_TOP   = 8'hff;
  localparam logic [7:0] CTM_CNT_ONE   = 8'h01;

  localparam logic [3:0] CTM_CS_STOP     = 4'h0;
  localparam logic [3:0] CTM_CS_FAST_MAX = 4'h4;
  localparam logic [3:0] CTM_CS_SYS_BASE = 4'h5;

  typedef enum logic [1:0] {
    CTM_ACT_OFF,
    CTM_ACT_TOGGLE,
    CTM_ACT_LOW,
    CTM_ACT_HIGH
  } ctm_action_t;

  typedef struct packed {
    logic        clear_on_match_enable;
    logic        pwm_a_enable;
    ctm_action_t out_action_a;
    logic [3:0]  clk_select;
  } ctm_ctrl_t;

endpackage

// ---- ctm_timer.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int FAST_PSC_W = 3,
  parameter int SYS_PSC_W  = 10
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fast_clk_tick,
  input  wire logic        global_irq_enable,
  input  wire logic        port_dir_out,
  input  wire logic        vec_ack_compare_a,
  input  wire logic        vec_ack_overflow,
  output logic             irq_compare_a,
  output logic             irq_overflow,
  output logic             compare_a_pin_out,
  output logic             compare_a_pin_oe_n
);

  ctm_ctrl_t              ctrl_q;
  logic [7:0]             cnt_q;
  logic [7:0]             cmp_a_q;
  logic [7:0]             cmp_a_buf_q;
  logic [7:0]             cmp_c_q;
  logic [7:0]             mask_q;
  logic                   flag_a_q;
  logic                   flag_ovf_q;
  logic [FAST_PSC_W-1:0]  fast_psc_q;
  logic [SYS_PSC_W-1:0]   sys_psc_q;
  logic                   cnt_wr_pend_q;
  logic [7:0]             cnt_wr_val_q;
  logic                   clr_req_q;
  logic                   ev_a_q;
  logic                   ev_ovf_q;
  logic                   clr_a_pend_q;
  logic                   clr_ovf_pend_q;
  logic                   pin_q;
  logic                   pready_q;

  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [7:0]  wd;
  logic        tick;
  logic [7:0]  cnt_inc;
  logic        match_a;
  logic        match_c;
  logic        ovf_ev;
  logic        force_a;
  logic        psc_rst;
  logic        connected;
  logic [31:0] rd_val;
  logic [3:0]  k;

  assign wd      = pwdata[7:0];
  assign wr_en   = psel & penable & pready_q & pwrite;
  assign rd_en   = psel & penable & ~pready_q & ~pwrite;
  assign mapped  = paddr inside {CTM_OFS_GEN_CTRL, CTM_OFS_CTRL,
                                 CTM_OFS_FLAGS, CTM_OFS_COUNT,
                                 CTM_OFS_CMP_A, CTM_OFS_CMP_C,
                                 CTM_OFS_MASK};
  assign psc_rst = wr_en & (paddr == CTM_OFS_GEN_CTRL)
                   & wd[CTM_BIT_PSC_RST];
  assign force_a = wr_en & (paddr == CTM_OFS_GEN_CTRL)
                   & wd[CTM_BIT_FORCE_A] & ~ctrl_q.pwm_a_enable;

  // Prescaled tick selection
  always_comb begin
    k    = 4'h0;
    tick = 1'b0;
    if (ctrl_q.clk_select == CTM_CS_STOP) begin
      tick = 1'b0;
    end else if (ctrl_q.clk_select <= CTM_CS_FAST_MAX) begin
      k    = ctrl_q.clk_select - 4'h1;
      tick = fast_clk_tick
             & (&(fast_psc_q | ~(((FAST_PSC_W)'(1) << k) - 1'b1)));
    end else begin
      k    = ctrl_q.clk_select - CTM_CS_SYS_BASE;
      tick = &(sys_psc_q | ~(((SYS_PSC_W)'(1) << k) - 1'b1));
    end
  end

  assign cnt_inc = cnt_q + 8'h01;
  // Matches only from counting, never from a pending write
  assign match_a = tick & ~cnt_wr_pend_q & ~clr_req_q
                   & (cnt_inc == cmp_a_q);
  assign match_c = tick & ~cnt_wr_pend_q & ~clr_req_q
                   & (cnt_inc == cmp_c_q);
  assign ovf_ev  = (tick & ~cnt_wr_pend_q & ~clr_req_q
                    & (cnt_q == CTM_CNT_TOP))
                   | (clr_req_q & ctrl_q.pwm_a_enable);
  assign connected = ctrl_q.pwm_a_enable ? ctrl_q.out_action_a[1]
                     : (ctrl_q.out_action_a != CTM_ACT_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_psc_q <= '0;
      sys_psc_q  <= '0;
    end else if (psc_rst) begin
      fast_psc_q <= '0;
      sys_psc_q  <= '0;
    end else begin
      sys_psc_q <= sys_psc_q + 1'b1;
      if (fast_clk_tick) begin
        fast_psc_q <= fast_psc_q + 1'b1;
      end
    end
  end

  // Counter and its delayed software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q         <= 8'h00;
      cnt_wr_pend_q <= 1'b0;
      cnt_wr_val_q  <= 8'h00;
      clr_req_q     <= 1'b0;
    end else begin
      cnt_wr_pend_q <= wr_en & (paddr == CTM_OFS_COUNT);
      cnt_wr_val_q  <= wd;
      clr_req_q     <= (ctrl_q.clear_on_match_enable
                        & (match_a | match_c))
                       | (ctrl_q.pwm_a_enable & match_c);
      if (cnt_wr_pend_q) begin
        cnt_q <= cnt_wr_val_q;
      end else if (clr_req_q) begin
        cnt_q <= 8'h00;
      end else if (tick) begin
        cnt_q <= cnt_inc;
      end
    end
  end

  // Control and compare registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= ctm_ctrl_t'(CTM_RST_CTRL);
      cmp_a_q     <= CTM_RST_CMP_A;
      cmp_a_buf_q <= CTM_RST_CMP_A;
      cmp_c_q     <= CTM_RST_CMP_C;
      mask_q      <= CTM_RST_MASK;
    end else begin
      if (wr_en && paddr == CTM_OFS_CTRL) begin
        ctrl_q <= ctm_ctrl_t'(wd);
      end
      if (wr_en && paddr == CTM_OFS_CMP_C) begin
        cmp_c_q <= wd;
      end
      if (wr_en && paddr == CTM_OFS_MASK) begin
        mask_q <= wd & ((8'h01 << CTM_BIT_FLAG_A)
                        | (8'h01 << CTM_BIT_FLAG_OVF));
      end
      if (wr_en && paddr == CTM_OFS_CMP_A) begin
        cmp_a_buf_q <= wd;
        if (!ctrl_q.pwm_a_enable) begin
          cmp_a_q <= wd;
        end
      end else if (ctrl_q.pwm_a_enable && match_c) begin
        cmp_a_q <= cmp_a_buf_q;
      end
    end
  end

  // Flags: events delayed one cycle, write clear requests delayed one cycle, vector clears not delayed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_a_q         <= 1'b0;
      ev_ovf_q       <= 1'b0;
      clr_a_pend_q   <= 1'b0;
      clr_ovf_pend_q <= 1'b0;
      flag_a_q       <= 1'b0;
      flag_ovf_q     <= 1'b0;
    end else begin
      ev_a_q         <= match_a;
      ev_ovf_q       <= ovf_ev;
      clr_a_pend_q   <= wr_en & (paddr == CTM_OFS_FLAGS)
                        & wd[CTM_BIT_FLAG_A];
      clr_ovf_pend_q <= wr_en & (paddr == CTM_OFS_FLAGS)
                        & wd[CTM_BIT_FLAG_OVF];
      if (ev_a_q) begin
        flag_a_q <= 1'b1;
      end else if (clr_a_pend_q || vec_ack_compare_a) begin
        flag_a_q <= 1'b0;
      end
      if (ev_ovf_q) begin
        flag_ovf_q <= 1'b1;
      end else if (clr_ovf_pend_q || vec_ack_overflow) begin
        flag_ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_compare_a <= 1'b0;
      irq_overflow  <= 1'b0;
    end else begin
      irq_compare_a <= mask_q[CTM_BIT_FLAG_A] & global_irq_enable
                       & flag_a_q;
      irq_overflow  <= mask_q[CTM_BIT_FLAG_OVF] & global_irq_enable
                       & flag_ovf_q;
    end
  end

  // Output compare pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q              <= 1'b0;
      compare_a_pin_oe_n <= 1'b1;
    end else begin
      compare_a_pin_oe_n <= ~(connected & port_dir_out);
      if (ctrl_q.pwm_a_enable) begin
        if (match_a) begin
          pin_q <= (ctrl_q.out_action_a == CTM_ACT_HIGH);
        end else if (tick && !cnt_wr_pend_q && !clr_req_q
                     && cnt_inc == CTM_CNT_ONE) begin
          pin_q <= (ctrl_q.out_action_a == CTM_ACT_LOW);
        end
      end else if (match_a || force_a) begin
        case (ctrl_q.out_action_a)
          CTM_ACT_TOGGLE: pin_q <= ~pin_q;
          CTM_ACT_LOW:    pin_q <= 1'b0;
          CTM_ACT_HIGH:   pin_q <= 1'b1;
          default:        pin_q <= pin_q;
        endcase
      end
    end
  end

  assign compare_a_pin_out = pin_q;

  // Read mux; strobe bits of the general control register read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      CTM_OFS_CTRL:  rd_val[7:0] = ctrl_q;
      CTM_OFS_COUNT: rd_val[7:0] = cnt_q;
      CTM_OFS_CMP_A: rd_val[7:0] = cmp_a_buf_q;
      CTM_OFS_CMP_C: rd_val[7:0] = cmp_c_q;
      CTM_OFS_MASK:  rd_val[7:0] = mask_q;
      CTM_OFS_FLAGS: begin
        rd_val[CTM_BIT_FLAG_A]   = flag_a_q;
        rd_val[CTM_BIT_FLAG_OVF] = flag_ovf_q;
      end
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr  <= psel & penable & ~pready_q & ~mapped;
      if (rd_en) begin
        prdata <= rd_val;
      end
    end
  end

  assign pready = pready_q;

endmodule

// ---- ctm_timer_sva.sv ----
`timescale 1ns/100ps
module ctm_timer_sva
  import ctm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        global_irq_enable,
  input wire logic        port_dir_out,
  input wire logic        irq_compare_a,
  input wire logic        irq_overflow,
  input wire logic        compare_a_pin_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = pready && psel && !pwrite;
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  bad_read_a: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  strobe_zero_a: assert property (
    rd && paddr == CTM_OFS_GEN_CTRL |-> prdata[7:0] == 8'h00)
    else $error("strobe bits read nonzero");
  reserved_zero_a: assert property (
    rd && (paddr == CTM_OFS_FLAGS || paddr == CTM_OFS_MASK)
    |-> !prdata[7] && !prdata[0]) else $error("reserved bit set");
  irq_a_gate_a: assert property (
    irq_compare_a |-> $past(global_irq_enable))
    else $error("compare irq without global enable");
  irq_ovf_gate_a: assert property (
    !global_irq_enable |=> !irq_overflow)
    else $error("overflow irq without global enable");
  pin_release_a: assert property (
    !port_dir_out |=> compare_a_pin_oe_n) else $error("pin driven as input");
  cover property (irq_compare_a);
  cover property (irq_overflow);
  cover property (rd && pslverr);
endmodule

// ---- test_compat_timer1_compare_pwm.sv ----
`timescale 1ns/100ps
module test_compat_timer1_compare_pwm import ctm_pkg::*; ;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        tick = 0, gie = 0, dir = 0, ack_a = 0, ack_o = 0, sl;
  logic        pready, pslverr, irq_a, irq_o, pin, oe_n;
  logic [7:0]  paddr = 8'h00, d;
  logic [31:0] pwdata = 32'h0, prdata, rv, sd = 32'h12322a8f;
  int          fails = 0, n_tests = 0, cy = 0, tk = 0, c, e, n0, t0;
  logic [7:0]  ra [8] = '{8'h2c, 8'h30, 8'h38, 8'h40, 8'h44, 8'h48, 8'h4c,
                          8'h3c};
  logic [7:0]  rx [8] = '{0, 0, 0, 0, 0, CTM_RST_CMP_C, 0, 0};
  logic [1:0]  fa [5] = '{3, 1, 1, 2, 0};
  logic        fx [5] = '{1, 0, 1, 0, 1};
  ctm_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_clk_tick(tick), .global_irq_enable(gie), .port_dir_out(dir),
    .vec_ack_compare_a(ack_a), .vec_ack_overflow(ack_o),
    .irq_compare_a(irq_a), .irq_overflow(irq_o),
    .compare_a_pin_out(pin), .compare_a_pin_oe_n(oe_n));
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected count from cycles or fast ticks seen in the window
  function automatic int expc(int c, int n, int t);
    return c < 5 ? t >> (c - 1) : n >> (c - 5);
  endfunction
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    sd <= xs(sd);
    tick <= sd[7];
    cy <= cy + 1;
    if (tick)
      tk <= tk + 1;
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [7:0] v);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {sd[31:8], v};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      complete_run();
    end
    rv = prdata;
    sl = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk("reset value", rv, {24'h0, rx[i]});
      chk("error flag", 32'(sl), 32'(ra[i] == 8'h3c));
    end
    $display("reset test done");
    repeat (6) begin
      d = sd[7:0];
      apb(1, 8'h40, d);
      apb(0, 8'h40, 0);
      chk("count", rv, {24'h0, d});
      apb(1, 8'h48, ~d);
      apb(0, 8'h48, 0);
      chk("top", rv, {24'h0, ~d});
    end
    $display("round trip test done");
    for (c = 1; c < 9; c++) begin
      apb(1, 8'h40, 0);
      apb(1, 8'h2c, 8'h02);
      apb(1, 8'h30, c[7:0]);
      n0 = cy;
      t0 = tk;
      cyc(64);
      apb(1, 8'h30, 0);
      e = expc(c, cy - n0, tk - t0);
      apb(0, 8'h40, 0);
      chk("rate", 32'(rv + 2 >= e && rv <= e + 2), 32'h1);
    end
    $display("clock select test done");
    dir <= 1;
    gie <= 1;
    apb(1, 8'h4c, 8'h44);
    apb(1, 8'h44, 8'h80);
    apb(1, 8'h40, 8'hfe);
    apb(1, 8'h30, 8'h05);
    cyc(4);
    apb(1, 8'h30, 0);
    apb(0, 8'h38, 0);
    chk("flags", rv, 32'h04);
    chk("overflow irq", 32'(irq_o), 32'h1);
    apb(1, 8'h38, 8'h04);
    cyc(2);
    chk("overflow irq", 32'(irq_o), 32'h0);
    apb(0, 8'h38, 0);
    chk("flags", rv, 32'h0);
    apb(1, 8'h40, 8'hfe);
    apb(1, 8'h30, 8'h05);
    cyc(4);
    apb(1, 8'h30, 0);
    ack_o <= 1;
    @(posedge pclk);
    ack_o <= 0;
    cyc(3);
    chk("overflow irq", 32'(irq_o), 32'h0);
    apb(0, 8'h38, 0);
    chk("flags", rv, 32'h0);
    $display("overflow test done");
    apb(1, 8'h48, 8'hff);
    apb(1, 8'h44, 8'h10);
    apb(1, 8'h40, 8'h10);
    cyc(3);
    apb(0, 8'h38, 0);
    chk("flags", rv, 32'h0);
    apb(1, 8'h40, 0);
    apb(1, 8'h30, 8'hb5);
    cyc(40);
    apb(1, 8'h30, 8'h30);
    apb(0, 8'h40, 0);
    chk("cleared count", 32'(rv <= 32'h10), 32'h1);
    chk("pin", 32'(pin), 32'h1);
    chk("compare irq", 32'(irq_a), 32'h1);
    ack_a <= 1;
    @(posedge pclk);
    ack_a <= 0;
    cyc(3);
    chk("compare irq", 32'(irq_a), 32'h0);
    $display("compare test done");
    foreach (fa[i]) begin
      apb(1, 8'h30, {2'b00, fa[i], 4'h0});
      apb(1, 8'h2c, 8'h04);
      cyc(2);
      chk("pin", 32'(fa[i] != 0 ? pin : oe_n), 32'(fx[i]));
    end
    apb(1, 8'h40, 8'h80);
    apb(1, 8'h30, 8'h70);
    apb(1, 8'h2c, 8'h04);
    cyc(2);
    chk("pin", 32'(pin), 32'h0);
    apb(1, 8'h44, 8'h5a);
    apb(0, 8'h44, 0);
    chk("held compare", rv, 32'h5a);
    apb(1, 8'h44, 8'h08);
    apb(1, 8'h48, 8'h20);
    apb(1, 8'h30, 8'h75);
    cyc(250);
    apb(0, 8'h40, 0);
    chk("pwm count", 32'(rv <= 32'h20), 32'h1);
    chk("pwm pin", 32'(oe_n), 32'h0);
    apb(0, 8'h38, 0);
    chk("flags", rv, 32'h44);
    apb(1, 8'h30, 0);
    $display("force test done");
    complete_run();
  end
endmodule
bind ctm_timer ctm_timer_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_irq_enable(global_irq_enable), .port_dir_out(port_dir_out),
  .irq_compare_a(irq_compare_a), .irq_overflow(irq_overflow),
  .compare_a_pin_oe_n(compare_a_pin_oe_n));
